// *** core/tp_link_polarity_monitor.sv ***
// tp_link_polarity_monitor: link, polarity and status report for TP ports.
// assumes per-port receive decode pulses and partition/util status inputs.
//
// Behaviour
// - no packet or link pulse for 60 ms sends port to link fail.
// - link fail ends after one packet, or six link pulses before 60 ms of total silence since fail/reset.
// - in link fail the port transmits neither packets nor link pulses.
// - the packet that restores link good is not repeated.
// - in link good, send a link pulse after 16 ms transmit idle.
// - link check disable forces the port to link good.
// - every reset re-enables link checking on all ports.
// - a negative first packet or three negative pulses after fail/reset mark negative.
// - negative ports repeat later packets inverted once link good.
// - non-negative ports repeat packets unchanged.
// - polarity holds until reset or next link fail entry.
// - polarity correction is switchable; reset enables it.
// - during reset polarity reads as correct.
// - one status output for attach port and one per TP port.
// - select 00 link/activity, 01 partition, 10 polarity, 11 utilization.
// - reset puts ports in link fail, checking on, transmitter idle.
`timescale 1ns/1ps
module tp_link_polarity_monitor
  import tp_link_pkg::*;
#(
  parameter int NPORT    = 8,
  parameter int FAIL_CYC = LINK_FAIL_CYC,
  parameter int IDLE_CYC = LINK_IDLE_CYC
)(
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic [NPORT-1:0] rx_pkt_in,
  input  wire logic [NPORT-1:0] rx_pkt_neg_in,
  input  wire logic [NPORT-1:0] rx_lp_in,
  input  wire logic [NPORT-1:0] rx_lp_neg_in,
  input  wire logic [NPORT-1:0] tx_busy_in,
  input  wire logic [NPORT-1:0] rx_activity_in,
  input  wire logic [NPORT-1:0] partition_in,
  input  wire logic [NPORT-1:0] util_in,
  input  wire logic             attach_col_act_in,
  input  wire logic             attach_partition_in,
  input  wire logic             attach_loop_err_in,
  input  wire logic             attach_util_in,
  input  wire logic             report_select_lo_in,
  input  wire logic             report_select_hi_in,
  input  wire logic             avs_read_in,
  input  wire logic             avs_write_in,
  input  wire logic [3:0]       avs_address_in,
  input  wire logic [31:0]      avs_writedata_in,
  input  wire logic [3:0]       avs_byteenable_in,
  output logic [31:0]           avs_readdata_out,
  output logic                  avs_waitrequest_out,
  output logic [NPORT-1:0]      link_good_out,
  output logic [NPORT-1:0]      pol_rev_out,
  output logic [NPORT-1:0]      invert_out,
  output logic [NPORT-1:0]      drop_pkt_out,
  output logic [NPORT-1:0]      tx_en_out,
  output logic [NPORT-1:0]      lp_send_out,
  output logic                  attach_port_status_out,
  output logic [NPORT-1:0]      tp_port_status_out
);
  logic [15:0]      en_r, en_nxt;
  logic [31:0]      rd_r, rd_nxt;
  logic             ack_r, ack_nxt;
  logic [NPORT-1:0] att_stat_r, att_stat_nxt;
  logic             aui_r, aui_nxt;
  logic [1:0]       sel;
  logic [NPORT-1:0] tp_stat;
  logic             aui_stat;
  logic [NPORT-1:0] link_chk_en, pol_corr_en;

  // enable register: bits 7:0 link check, 15:8 polarity correction
  assign link_chk_en = en_r[NPORT-1:0];
  assign pol_corr_en = en_r[NPORT+7:8];

  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : g_port
      tp_port_link #(
        .FAIL_CYC (FAIL_CYC),
        .IDLE_CYC (IDLE_CYC)
      ) u_port (
        .mclk_in        (mclk_in),
        .rst_in         (rst_in),
        .rx_pkt_in      (rx_pkt_in[g]),
        .rx_pkt_neg_in  (rx_pkt_neg_in[g]),
        .rx_lp_in       (rx_lp_in[g]),
        .rx_lp_neg_in   (rx_lp_neg_in[g]),
        .tx_busy_in     (tx_busy_in[g]),
        .link_chk_en_in (link_chk_en[g]),
        .pol_corr_en_in (pol_corr_en[g]),
        .link_good_out  (link_good_out[g]),
        .pol_rev_out    (pol_rev_out[g]),
        .invert_out     (invert_out[g]),
        .drop_pkt_out   (drop_pkt_out[g]),
        .tx_en_out      (tx_en_out[g]),
        .lp_send_out    (lp_send_out[g])
      );
    end
  endgenerate

  // status mux; link/activity shows activity blink over link good
  assign sel = {report_select_hi_in, report_select_lo_in};
  always_comb
  begin
    case (sel)
      SEL_LINK:
      begin
        tp_stat  = link_good_out ^ rx_activity_in;
        aui_stat = attach_col_act_in;
      end
      SEL_PART:
      begin
        tp_stat  = partition_in;
        aui_stat = attach_partition_in;
      end
      SEL_POL:
      begin
        tp_stat  = pol_rev_out;
        aui_stat = attach_loop_err_in;
      end
      SEL_UTIL:
      begin
        tp_stat  = util_in;
        aui_stat = attach_util_in;
      end
      default:
      begin
        tp_stat  = '0;
        aui_stat = 1'b0;
      end
    endcase
    att_stat_nxt = tp_stat;
    aui_nxt      = aui_stat;
  end

  // registered LED drive; one cycle behind the select pins
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      att_stat_r <= '0;
      aui_r      <= 1'b0;
    end
    else
    begin
      att_stat_r <= att_stat_nxt;
      aui_r      <= aui_nxt;
    end
  end
  assign tp_port_status_out     = att_stat_r;
  assign attach_port_status_out = aui_r;

  // Avalon slave: one wait state, answer on the second edge
  always_comb
  begin
    en_nxt  = en_r;
    rd_nxt  = rd_r;
    ack_nxt = 1'b0;
    if ((avs_read_in || avs_write_in) && ack_r)
    begin
      // write lands only at the edge that sees waitrequest low
      if (avs_write_in && {26'h0, avs_address_in, 2'h0} == ENABLE_REG)
      begin
        if (avs_byteenable_in[0])
          en_nxt[7:0] = avs_writedata_in[7:0];
        if (avs_byteenable_in[1])
          en_nxt[15:8] = avs_writedata_in[15:8];
      end
    end
    else if (avs_read_in || avs_write_in)
    begin
      ack_nxt = 1'b1;
      rd_nxt  = 32'h0000_0000;
      if (avs_read_in)
      begin
        case ({26'h0, avs_address_in, 2'h0})
          ENABLE_REG: rd_nxt = {16'h0, en_r};
          STATUS_REG: rd_nxt = {16'h0, 8'(pol_rev_out),
                                8'(link_good_out)};
          default:    rd_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      en_r  <= ENABLE_RST;
      rd_r  <= 32'h0000_0000;
      ack_r <= 1'b0;
    end
    else
    begin
      en_r  <= en_nxt;
      rd_r  <= rd_nxt;
      ack_r <= ack_nxt;
    end
  end
  assign avs_readdata_out    = rd_r;
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_r;

  chk_reset_enables: assert property (@(posedge mclk_in)
    $fell(rst_in) |-> (en_r == ENABLE_RST))
    else $error("enables not restored by reset");
  chk_pol_report: assert property (@(posedge mclk_in) disable iff (rst_in)
    (sel == SEL_POL) |=> (tp_port_status_out == $past(pol_rev_out)))
    else $error("polarity report mismatch");
endmodule : tp_link_polarity_monitor

// *** core/tp_link_pkg.sv ***
// tp_link_pkg: constants for the twisted-pair link / polarity monitor.
// assumes a 100 MHz mclk_in; times are converted to cycles here.
package tp_link_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          LINK_FAIL_MS   = 60;
  localparam int          LINK_IDLE_MS   = 16;
  // longest timer: 60 ms is 6000000 cycles, inside the 24-bit TMR_W range
  localparam int          LINK_FAIL_CYC  = LINK_FAIL_MS * 1000 * CLK_MHZ;
  localparam int          LINK_IDLE_CYC  = LINK_IDLE_MS * 1000 * CLK_MHZ;
  localparam int          TMR_W          = 24;
  localparam logic [2:0]  GOOD_PULSES    = 3'h6;
  localparam logic [1:0]  NEG_PULSES     = 2'h3;
  localparam logic [1:0]  SEL_LINK       = 2'h0;
  localparam logic [1:0]  SEL_PART       = 2'h1;
  localparam logic [1:0]  SEL_POL        = 2'h2;
  localparam logic [1:0]  SEL_UTIL       = 2'h3;
  localparam int          ENABLE_REG     = 32'h0000_0000;
  localparam int          STATUS_REG     = 32'h0000_0004;
  localparam logic [15:0] ENABLE_RST     = 16'hFFFF;

  typedef enum logic [1:0] {
    LS_FAIL = 2'b01,
    LS_GOOD = 2'b10
  } link_state_t;
endpackage : tp_link_pkg

// *** core/tp_port_link.sv ***
// tp_port_link: link integrity and polarity latch for one twisted-pair port.
// assumes receive events arrive as one-cycle pulses on mclk_in.
`timescale 1ns/1ps
module tp_port_link
  import tp_link_pkg::*;
#(
  parameter int FAIL_CYC = LINK_FAIL_CYC,
  parameter int IDLE_CYC = LINK_IDLE_CYC
)(
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic rx_pkt_in,
  input  wire logic rx_pkt_neg_in,
  input  wire logic rx_lp_in,
  input  wire logic rx_lp_neg_in,
  input  wire logic tx_busy_in,
  input  wire logic link_chk_en_in,
  input  wire logic pol_corr_en_in,
  output logic      link_good_out,
  output logic      pol_rev_out,
  output logic      invert_out,
  output logic      drop_pkt_out,
  output logic      tx_en_out,
  output logic      lp_send_out
);
  link_state_t      st_r, st_nxt;
  logic [TMR_W-1:0] rx_tmr_r, rx_tmr_nxt, tx_tmr_r, tx_tmr_nxt;
  logic [2:0]       lp_cnt_r, lp_cnt_nxt;
  logic [1:0]       neg_cnt_r, neg_cnt_nxt;
  logic             pol_det_r, pol_det_nxt, pol_neg_r, pol_neg_nxt;
  logic             lp_r, lp_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    rx_tmr_nxt  = rx_tmr_r;
    tx_tmr_nxt  = tx_tmr_r;
    lp_cnt_nxt  = lp_cnt_r;
    neg_cnt_nxt = neg_cnt_r;
    pol_det_nxt = pol_det_r;
    pol_neg_nxt = pol_neg_r;
    lp_nxt      = 1'b0;
    // polarity decided once per fail episode
    if (!pol_det_r)
    begin
      if (rx_pkt_in)
      begin
        pol_det_nxt = 1'b1;
        pol_neg_nxt = rx_pkt_neg_in;
      end
      else if (rx_lp_in)
      begin
        if (!rx_lp_neg_in)
        begin
          neg_cnt_nxt = 2'h0;
          pol_det_nxt = 1'b1;
        end
        else if (neg_cnt_r == NEG_PULSES - 2'h1)
        begin
          pol_det_nxt = 1'b1;
          pol_neg_nxt = 1'b1;
        end
        else
          neg_cnt_nxt = neg_cnt_r + 2'h1;
      end
    end
    case (st_r)
      LS_FAIL:
      begin
        tx_tmr_nxt = '0;
        if (!link_chk_en_in || rx_pkt_in ||
            (rx_lp_in && lp_cnt_r == GOOD_PULSES - 3'h1))
        begin
          st_nxt     = LS_GOOD;
          rx_tmr_nxt = '0;
          lp_cnt_nxt = 3'h0;
        end
        else if (rx_lp_in)
          lp_cnt_nxt = lp_cnt_r + 3'h1;
        else if (rx_tmr_r >= TMR_W'(FAIL_CYC))
          lp_cnt_nxt = 3'h0; // run broken by silence
        else
          rx_tmr_nxt = rx_tmr_r + 1'b1;
      end
      LS_GOOD:
      begin
        if (rx_pkt_in || rx_lp_in || !link_chk_en_in)
          rx_tmr_nxt = '0;
        else if (rx_tmr_r >= TMR_W'(FAIL_CYC))
        begin
          st_nxt      = LS_FAIL;
          rx_tmr_nxt  = '0;
          pol_det_nxt = 1'b0; // re-learn
          pol_neg_nxt = 1'b0;
          neg_cnt_nxt = 2'h0;
        end
        else
          rx_tmr_nxt = rx_tmr_r + 1'b1;
        if (tx_busy_in)
          tx_tmr_nxt = '0;
        else if (tx_tmr_r >= TMR_W'(IDLE_CYC))
        begin
          lp_nxt     = 1'b1;
          tx_tmr_nxt = '0;
        end
        else
          tx_tmr_nxt = tx_tmr_r + 1'b1;
      end
      default: st_nxt = LS_FAIL;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r      <= LS_FAIL;
      rx_tmr_r  <= '0;
      tx_tmr_r  <= '0;
      lp_cnt_r  <= 3'h0;
      neg_cnt_r <= 2'h0;
      pol_det_r <= 1'b0;
      pol_neg_r <= 1'b0;
      lp_r      <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      rx_tmr_r  <= rx_tmr_nxt;
      tx_tmr_r  <= tx_tmr_nxt;
      lp_cnt_r  <= lp_cnt_nxt;
      neg_cnt_r <= neg_cnt_nxt;
      pol_det_r <= pol_det_nxt;
      pol_neg_r <= pol_neg_nxt;
      lp_r      <= lp_nxt;
    end
  end

  assign link_good_out = (st_r == LS_GOOD);
  assign pol_rev_out   = pol_neg_r;
  // inversion needs correction enabled and a good link
  assign invert_out    = pol_neg_r && pol_corr_en_in && link_good_out;
  assign drop_pkt_out  = (st_r == LS_FAIL);
  assign tx_en_out     = link_good_out;
  assign lp_send_out   = lp_r && link_good_out;

  chk_fail_silent: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st_r == LS_FAIL) |-> (!tx_en_out && !lp_send_out))
    else $error("transmit active while in link fail");
  chk_disable_good: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!link_chk_en_in && st_r == LS_FAIL) |=> (st_r == LS_GOOD))
    else $error("link check disabled but port stayed failed");
  chk_pkt_restore: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st_r == LS_FAIL && rx_pkt_in) |=> link_good_out)
    else $error("packet did not restore link good");
  chk_pol_latched: assert property (@(posedge mclk_in) disable iff (rst_in)
    (pol_det_r && st_r == LS_GOOD && st_nxt == LS_GOOD)
      |=> $stable(pol_neg_r))
    else $error("latched polarity changed");
  chk_no_invert: assert property (@(posedge mclk_in) disable iff (rst_in)
    !pol_neg_r |-> !invert_out)
    else $error("inversion without negative polarity");
  chk_pkt_neg: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!pol_det_r && rx_pkt_in && rx_pkt_neg_in) |=> pol_neg_r)
    else $error("negative packet not latched");
  chk_fail_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st_r == LS_GOOD ##1 st_r == LS_FAIL) |-> !pol_neg_r)
    else $error("polarity not cleared on link fail");
  chk_lp_good: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(lp_send_out) |-> $past(link_good_out))
    else $error("link pulse outside link good");
endmodule : tp_port_link

// *** test/tp_remote_model.sv ***
// tp_remote_model: far-end twisted-pair ports, one lane per port.
// assumes bench requests last one mclk_in cycle each.
`timescale 1ns/1ps
module tp_remote_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] pkt_req_in,
  input  wire logic [7:0] lp_req_in,
  input  wire logic [7:0] neg_in,
  input  wire logic [7:0] tx_en_in,
  input  wire logic [7:0] lp_send_in,
  output logic      [7:0] rx_pkt_out,
  output logic      [7:0] rx_pkt_neg_out,
  output logic      [7:0] rx_lp_out,
  output logic      [7:0] rx_lp_neg_out,
  output logic      [7:0] bad_tx_out
);
  initial
  begin
    rx_pkt_out = 8'h00;
    rx_lp_out = 8'h00;
    rx_pkt_neg_out = 8'h00;
    rx_lp_neg_out = 8'h00;
    bad_tx_out = 8'h00;
  end
  // idle polarity lines toggle so a stale level never looks valid
  always @(posedge mclk_in)
  begin
    rx_pkt_out <= pkt_req_in;
    rx_lp_out <= lp_req_in;
    rx_pkt_neg_out <= (pkt_req_in & neg_in) | (~pkt_req_in & ~rx_pkt_neg_out);
    rx_lp_neg_out <= (lp_req_in & neg_in) | (~lp_req_in & ~rx_lp_neg_out);
    bad_tx_out <= bad_tx_out | (lp_send_in & ~tx_en_in);
  end
endmodule : tp_remote_model

// *** test/tp_link_polarity_monitor_tb_top.sv ***
// tp_link_polarity_monitor_tb_top: scenario bench for the link monitor.
// assumes shortened timers; far ports come from tp_remote_model.
`timescale 1ns/1ps
module tp_link_polarity_monitor_tb_top;
  import tp_link_pkg::*;
  localparam int FC = 50;
  localparam int IC = 20;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  pkt_req = 8'h00, lp_req = 8'h00, neg = 8'h00;
  logic [7:0]  busy = 8'h00, act = 8'h10, part = 8'h3C, util = 8'hA5;
  logic [3:0]  att = 4'hA, addr = 4'h0, be = 4'h0;
  logic [1:0]  sel = 2'h0;
  logic        rd = 1'b0, wr = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [7:0]  rxp, rxpn, rxl, rxln, lg, pr, inv, drop, txen, lps, tps, bad;
  logic        wreq, ats;
  int          failures = 0, checks = 0;

  always #5 mclk_in = ~mclk_in;

  tp_remote_model tp_remote_model_i (.mclk_in(mclk_in), .pkt_req_in(pkt_req),
    .lp_req_in(lp_req), .neg_in(neg), .tx_en_in(txen), .lp_send_in(lps),
    .rx_pkt_out(rxp), .rx_pkt_neg_out(rxpn), .rx_lp_out(rxl),
    .rx_lp_neg_out(rxln), .bad_tx_out(bad));

  tp_link_polarity_monitor #(.NPORT(8), .FAIL_CYC(FC), .IDLE_CYC(IC))
  tp_link_polarity_monitor_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .rx_pkt_in(rxp), .rx_pkt_neg_in(rxpn), .rx_lp_in(rxl),
    .rx_lp_neg_in(rxln), .tx_busy_in(busy), .rx_activity_in(act),
    .partition_in(part), .util_in(util), .attach_col_act_in(att[0]),
    .attach_partition_in(att[1]), .attach_loop_err_in(att[2]),
    .attach_util_in(att[3]), .report_select_lo_in(sel[0]),
    .report_select_hi_in(sel[1]), .avs_read_in(rd), .avs_write_in(wr),
    .avs_address_in(addr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .link_good_out(lg), .pol_rev_out(pr),
    .invert_out(inv), .drop_pkt_out(drop), .tx_en_out(txen),
    .lp_send_out(lps), .attach_port_status_out(ats),
    .tp_port_status_out(tps));

  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  // call just after a rising edge; returns just after one
  // waitrequest and read data are looked at while settled before the edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int   n;
    logic wq;
    n = 0;
    wq = 1'b1;
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    while (wq !== 1'b0)
    begin
      @(negedge mclk_in);
      wq = wreq;
      q = rdata;
      @(posedge mclk_in);
      n++;
      if (n > 20)
      begin
        failures++;
        conclude();
      end
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_in);
  endtask : bus

  task automatic pulse(input logic [7:0] p, input logic lp, input logic ng);
    if (lp)
      lp_req <= p;
    else
      pkt_req <= p;
    neg <= ng ? p : 8'h00;
    @(posedge mclk_in);
    lp_req <= 8'h00;
    pkt_req <= 8'h00;
    @(posedge mclk_in);
  endtask : pulse

  task automatic do_reset;
    rst_in <= 1'b1;
    repeat (16) @(posedge mclk_in);
    @(negedge mclk_in);
    cmp(pr, 8'h00);
    cmp({lg, txen, lps}, 24'h0);
    cmp(drop, 8'hFF);
    @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    cmp(q, 32'h0000FFFF);
    bus(1'b0, 4'h1, 32'h0, 4'hF);
    cmp(q, 32'h0);
    bus(1'b0, 4'h5, 32'h0, 4'hF);
    cmp(q, 32'h0);
  endtask : do_reset

  task automatic sc_link_idle;
    int n;
    n = 0;
    pulse(8'h01, 1'b0, 1'b0);
    while (lps[0] !== 1'b1 && n < IC + 10)
    begin
      @(negedge mclk_in);
      n++;
    end
    cmp({lg[0], pr[0], inv[0]}, 3'b100);
    cmp(32'(n > IC - 3 && n < IC + 4), 1);
    @(posedge mclk_in);
    repeat (5) pulse(8'h02, 1'b1, 1'b1);
    @(negedge mclk_in);
    cmp(lg[1], 1'b0);
    @(posedge mclk_in);
    pulse(8'h02, 1'b1, 1'b1);
    @(negedge mclk_in);
    cmp({lg[1], pr[1], inv[1]}, 3'b111);
    @(posedge mclk_in);
  endtask : sc_link_idle

  task automatic sc_report;
    logic [7:0] tpx [4];
    logic       atx [4];
    tpx = '{8'h13, 8'h3C, 8'h02, 8'hA5};
    atx = '{1'b0, 1'b1, 1'b0, 1'b1};
    pulse(8'h01, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      sel <= 2'(k);
      repeat (2) @(posedge mclk_in);
      @(negedge mclk_in);
      cmp(tps, tpx[k]);
      cmp(ats, atx[k]);
      @(posedge mclk_in);
    end
  endtask : sc_report

  task automatic sc_enables;
    bus(1'b1, 4'h0, 32'h0, 4'b0010);
    @(negedge mclk_in);
    cmp({inv[1], pr[1]}, 2'b01);
    @(posedge mclk_in);
    bus(1'b0, 4'h1, 32'h0, 4'hF);
    cmp(q, 32'h00000203);
    bus(1'b1, 4'h0, 32'h0000FFFB, 4'b0011);
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    cmp({lg[2], txen[2]}, 2'b11);
    @(posedge mclk_in);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    cmp(q, 32'h0000FFFB);
  endtask : sc_enables

  task automatic sc_fail;
    repeat (FC + 10) @(posedge mclk_in);
    @(negedge mclk_in);
    cmp(lg, 8'h04);
    cmp(pr, 8'h00);
    cmp(bad, 8'h00);
    @(posedge mclk_in);
    pulse(8'h08, 1'b0, 1'b1);
    @(negedge mclk_in);
    cmp({lg[3], pr[3]}, 2'b11);
    @(posedge mclk_in);
  endtask : sc_fail

  initial
  begin
    #200000;
    failures++;
    conclude();
  end

  initial
  begin
    do_reset();
    sc_link_idle();
    sc_report();
    sc_enables();
    sc_fail();
    do_reset();
    conclude();
  end
endmodule : tp_link_polarity_monitor_tb_top
